// ---- vtb_top.sv ----
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module vtb_top
	import vtb_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire vtb_pins_t pins,
	output logic clk_div2_n,
	output logic clk_div8_n,
	output logic buffered_ctrl_bus_en_n,
	output logic bus_en,
	output logic timing_halt_n,
	output logic data_bus_en_n,
	output logic [4:0] timing_rom_addr,
	output logic [7:0] timing_out,
	output logic rmw_cycle_n,
	output logic rmw_cycle,
	output logic screen_blank_n,
	output logic video_blank_n,
	output logic video_blank,
	output logic dac_blank_n,
	output logic plane_select,
	output logic byte_select_n,
	output logic display_addr_bit3,
	output logic vector_mode_n,
	output logic display_addr_select_n,
	output logic local_addr_select_n,
	output logic [7:0] mem_addr,
	output logic [5:0] write_mode_sel,
	output logic write_mask_zero,
	output logic bg_erase
);

	vtb_state_t st_r;
	vtb_state_t st_nxt;

	logic scroll_en;
	logic halt;
	logic rmw_act;
	logic end_fall;
	logic ras_fall;
	logic ras_rise;
	logic cas_fall;
	logic rah_rise;
	logic sync_rise;
	logic rmw_rise;
	logic vec_on;
	logic bus_take;
	logic dec_en;
	logic [7:0] col_byte;
	logic [$bits(vtb_pins_t) - 1:0] agree;

	// one decoder shared by the output selects and the status readback
	function automatic logic [5:0] mode_dec(input logic [2:0] code);
		logic [5:0] oh;
		oh = 6'h00;
		case (code)
			VTB_MODE_TEXT: oh = 6'h02;
			VTB_MODE_VECTOR: oh = 6'h04;
			VTB_MODE_SCROLL: oh = 6'h08;
			VTB_MODE_FRAME_ERASE: oh = 6'h10;
			VTB_MODE_WORD_ERASE: oh = 6'h20;
			default: oh = 6'h01; // unused codes fall back to readback
		endcase
		return oh;
	endfunction

	function automatic logic fell(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction

	// pulse decode from the registered timing word and its last value
	assign end_fall = fell(st_r.tim_prev[VTB_T_END], st_r.tim[VTB_T_END]);
	assign ras_fall = fell(st_r.tim_prev[VTB_T_RAS], st_r.tim[VTB_T_RAS]);
	assign ras_rise = fell(st_r.tim[VTB_T_RAS], st_r.tim_prev[VTB_T_RAS]);
	assign cas_fall = fell(st_r.tim_prev[VTB_T_CAS], st_r.tim[VTB_T_CAS]);
	assign rah_rise = fell(st_r.tim[VTB_T_RAH], st_r.tim_prev[VTB_T_RAH]);
	assign sync_rise = fell(st_r.tim[VTB_T_SYNC], st_r.tim_prev[VTB_T_SYNC]);

	// control glue seen by the controller, the memory and the converter
	assign scroll_en = st_r.mode1[VTB_M1_SCROLL_EN];
	assign bus_en = ~st_r.pin_f.ctrl_bus_en_n;
	assign buffered_ctrl_bus_en_n = st_r.pin_f.ctrl_bus_en_n;
	assign halt = st_r.tim[VTB_T_HALT] & bus_en;
	assign timing_halt_n = ~halt;
	assign data_bus_en_n = ~(st_r.tim[VTB_T_DBEN] & bus_en);
	assign rmw_act = st_r.rmw | st_r.erase;
	assign rmw_rise = rmw_act & ~st_r.rmw_prev;
	assign rmw_cycle_n = ~rmw_act;
	assign rmw_cycle = rmw_act;
	assign vec_on = st_r.wmode[2];
	assign vector_mode_n = ~vec_on;
	assign display_addr_bit3 = (~st_r.pin_f.local_addr_top & ~vec_on) |
		(~st_r.pin_f.high_byte_active & vec_on);
	// decoder only opens during scrolled blanking
	assign dec_en = st_r.sblank & scroll_en;
	assign display_addr_select_n =
		~(dec_en & ~st_r.pin_f.ctrl_source_select & rmw_act);
	assign local_addr_select_n =
		~(dec_en & st_r.pin_f.ctrl_source_select);
	assign bus_take = st_r.ack & avs_write & avs_byteenable[0];
	assign agree = ~(st_r.pin_s2 ^ st_r.pin_s3);

	// column byte with plane select (vector mode) or display bit 3 dropped into bit 3, and byte select into bit 6
	always_comb begin
		col_byte = st_r.latched[15:8];
		col_byte[3] = vec_on ? st_r.ps : display_addr_bit3;
		col_byte[6] = st_r.bs;
	end

	// whole next state; the register bank below only captures it
	always_comb begin
		st_nxt = st_r;
		// three-stage pin capture, a change counts when stages 2 and 3 agree
		st_nxt.pin_s1 = pins;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.pin_s3 = st_r.pin_s2;
		st_nxt.pin_f = vtb_pins_t'((st_r.pin_f & ~agree) |
			(st_r.pin_s3 & agree));
		st_nxt.div = st_r.div + 3'h1;
		// clear flop lags halt by one clock; the counter clear follows one clock after it
		st_nxt.clr = halt;
		st_nxt.cnt = st_r.clr ? 4'h0 : st_r.cnt + 4'h1;
		st_nxt.msb = ~(scroll_en | halt);
		st_nxt.tim = VTB_TIMING_ROM[{st_r.msb, st_r.cnt}];
		st_nxt.tim_prev = st_r.tim;
		if (end_fall) begin
			st_nxt.rmw = bus_en;
		end
		if (ras_fall) begin
			st_nxt.erase = ~st_r.pin_f.erase_req_n;
		end
		st_nxt.rmw_prev = rmw_act;
		if (rah_rise) begin
			st_nxt.sblank = st_r.pin_f.ctrl_video_suppress;
		end
		if (sync_rise) begin
			st_nxt.blank = st_r.pin_f.ctrl_video_suppress;
		end
		st_nxt.dpipe = {st_r.dpipe[1:0], st_r.blank};
		// plane fires on first column strobe fall, byte on the second
		if (!st_r.tim[VTB_T_RAS]) begin
			st_nxt.ps = 1'b0;
			st_nxt.bs = 1'b0;
		end else if (cas_fall) begin
			if (!st_r.ps) begin
				st_nxt.ps = 1'b1;
			end else begin
				st_nxt.bs = 1'b1;
			end
		end
		// a software load beats a count in the same clock
		if (bus_take && avs_address == VTB_OFS_SCROLL_LO) begin
			st_nxt.scroll[7:0] = avs_writedata[7:0];
		end else if (bus_take && avs_address == VTB_OFS_SCROLL_HI) begin
			st_nxt.scroll[13:8] = avs_writedata[5:0];
		end else if (rmw_rise) begin
			st_nxt.scroll = st_r.mode1[VTB_M1_DIR] ?
				st_r.scroll - 14'h0001 : st_r.scroll + 14'h0001;
		end
		if (ras_rise) begin
			st_nxt.latched = (!scroll_en && rmw_act) ?
				st_r.pin_f.ctrl_addr_data : {2'h0, st_r.scroll};
		end
		st_nxt.mem_addr = st_r.tim[VTB_T_RAH] ?
			st_r.latched[7:0] : col_byte;
		st_nxt.wmode = mode_dec(st_r.mode0[2:0]);
		// register writes land on the edge where waitrequest is low
		if (bus_take && avs_address == VTB_OFS_MODE0) begin
			st_nxt.mode0 = avs_writedata[7:0];
		end
		if (bus_take && avs_address == VTB_OFS_MODE1) begin
			st_nxt.mode1 = avs_writedata[7:0];
		end
		// one wait cycle per access gives time to register read data
		st_nxt.ack = (avs_read | avs_write) & ~st_r.ack;
		if (avs_read && !st_r.ack) begin
			case (avs_address)
				VTB_OFS_MODE0: st_nxt.rdata = {24'h0, st_r.mode0};
				VTB_OFS_MODE1: st_nxt.rdata = {24'h0, st_r.mode1};
				VTB_OFS_STATUS: st_nxt.rdata = {15'h0, st_r.wmode,
					st_r.msb, st_r.cnt, st_r.blank, st_r.sblank,
					st_r.bs, st_r.ps, st_r.erase, rmw_act};
				VTB_OFS_SCROLL_LO: st_nxt.rdata = {24'h0, st_r.scroll[7:0]};
				VTB_OFS_SCROLL_HI:
					st_nxt.rdata = {26'h0, st_r.scroll[13:8]};
				VTB_OFS_LATCH: st_nxt.rdata = {16'h0, st_r.latched};
				default: st_nxt.rdata = 32'h0;
			endcase
		end
	end

	// all state in one bank; synchronous reset to defined values
	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_r <= '0;
			st_r.mode0 <= VTB_MODE0_RST;
			st_r.mode1 <= VTB_MODE1_RST;
			st_r.scroll <= VTB_SCROLL_RST;
			st_r.msb <= 1'b1;
			st_r.pin_f.ctrl_bus_en_n <= 1'b1;
			st_r.pin_f.erase_req_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// output drive from the state bank
	assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
	assign avs_readdata = st_r.rdata;
	assign clk_div2_n = st_r.div[0];
	assign clk_div8_n = st_r.div[2];
	assign timing_rom_addr = {st_r.msb, st_r.cnt};
	assign timing_out = st_r.tim;
	assign screen_blank_n = ~st_r.sblank;
	assign video_blank_n = ~st_r.blank;
	assign video_blank = st_r.blank;
	assign dac_blank_n = ~st_r.dpipe[2];
	assign plane_select = st_r.ps;
	assign byte_select_n = ~st_r.bs;
	assign mem_addr = st_r.mem_addr;
	assign write_mode_sel = st_r.wmode;
	assign write_mask_zero = st_r.wmode[3];
	assign bg_erase = st_r.wmode[4] | st_r.wmode[5];

	default clocking vtb_cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	AST_CLR_HOLDS: assert property (st_r.clr |=> st_r.cnt == 4'h0)
		else $error("timing counter not cleared by halt");
	AST_CNT_STEP: assert property (!st_r.clr |=>
		st_r.cnt == 4'($past(st_r.cnt) + 4'h1))
		else $error("timing counter did not advance");
	AST_CNT_WRAP: assert property (!st_r.clr && st_r.cnt == 4'hf
		|=> st_r.cnt == 4'h0)
		else $error("timing counter did not wrap");
	AST_MSB_LOW: assert property ((scroll_en || !timing_halt_n)
		|=> !timing_rom_addr[4])
		else $error("address top bit not low in scroll or halt");
	AST_ROM_REG: assert property (1'b1 |=>
		timing_out == VTB_TIMING_ROM[$past(timing_rom_addr)])
		else $error("timing word does not match table");
	AST_RMW_SAMPLE: assert property (end_fall |=>
		st_r.rmw == $past(bus_en))
		else $error("rmw not sampled at cycle end");
	AST_ERASE_FORCE: assert property (st_r.erase |-> !rmw_cycle_n)
		else $error("erase did not force rmw");
	AST_DBLANK3: assert property (1'b1 |-> ##3
		dac_blank_n == $past(video_blank_n, 3))
		else $error("converter blank not three clocks late");
	AST_PS_CLEAR: assert property (!st_r.tim[VTB_T_RAS] |=>
		!plane_select && byte_select_n)
		else $error("plane or byte select set outside row strobe");
	AST_LATCH: assert property (ras_rise && !scroll_en && rmw_act
		|=> st_r.latched == $past(st_r.pin_f.ctrl_addr_data))
		else $error("controller address not latched");
	AST_ROWCOL: assert property (timing_out[VTB_T_RAH] |=>
		mem_addr == $past(st_r.latched[7:0]))
		else $error("row address not presented");
	AST_SCROLL_DN: assert property (rmw_rise && !bus_take &&
		st_r.mode1[VTB_M1_DIR] |=> st_r.scroll == 14'($past(st_r.scroll) -
		14'h0001))
		else $error("scroll counter did not count down");

	COV_RMW: cover property (end_fall && bus_en ##1 rmw_cycle);
	COV_ERASE: cover property (st_r.erase);
	COV_PLANE_BYTE: cover property (plane_select ##[1:16] !byte_select_n);
	COV_WORD_ERASE: cover property (write_mode_sel[5]);

endmodule

// ---- vtb_pkg.sv ----
package vtb_pkg;

	// core clock rate; the timing engine steps once per core clock
	localparam int VTB_CORE_CLK_HZ = 10_000_000;
	localparam int VTB_ROM_STEPS = 16;
	localparam int VTB_DBLANK_DELAY = 3;

	// register byte offsets on the avalon slave
	localparam logic [4:0] VTB_OFS_MODE0 = 5'h00;
	localparam logic [4:0] VTB_OFS_MODE1 = 5'h04;
	localparam logic [4:0] VTB_OFS_STATUS = 5'h08;
	localparam logic [4:0] VTB_OFS_SCROLL_LO = 5'h0c;
	localparam logic [4:0] VTB_OFS_SCROLL_HI = 5'h10;
	localparam logic [4:0] VTB_OFS_LATCH = 5'h14;

	// reset values and field positions
	localparam logic [7:0] VTB_MODE0_RST = 8'h00;
	localparam logic [7:0] VTB_MODE1_RST = 8'h00;
	localparam logic [13:0] VTB_SCROLL_RST = 14'h0000;
	localparam int VTB_M1_SCROLL_EN = 0;
	localparam int VTB_M1_DIR = 1;

	// write mode codes held in mode register zero, bits 2:0
	localparam logic [2:0] VTB_MODE_READBACK = 3'h0;
	localparam logic [2:0] VTB_MODE_TEXT = 3'h1;
	localparam logic [2:0] VTB_MODE_VECTOR = 3'h2;
	localparam logic [2:0] VTB_MODE_SCROLL = 3'h3;
	localparam logic [2:0] VTB_MODE_FRAME_ERASE = 3'h4;
	localparam logic [2:0] VTB_MODE_WORD_ERASE = 3'h5;

	// timing lookup table output bit positions
	localparam int VTB_T_RAH = 0;
	localparam int VTB_T_CAS = 1;
	localparam int VTB_T_RAS = 2;
	localparam int VTB_T_END = 3;
	localparam int VTB_T_SYNC = 4;
	localparam int VTB_T_HALT = 5;
	localparam int VTB_T_DBEN = 6;

	// lower half: scroll or halt firmware, upper half: normal display
	localparam logic [7:0] VTB_TIMING_ROM [32] = '{
		8'h31, 8'h11, 8'h15, 8'h15, 8'h15, 8'h15, 8'h16, 8'h16,
		8'h06, 8'h44, 8'h46, 8'h46, 8'h46, 8'h44, 8'h08, 8'h00,
		8'h11, 8'h11, 8'h15, 8'h15, 8'h15, 8'h15, 8'h16, 8'h16,
		8'h06, 8'h44, 8'h46, 8'h46, 8'h46, 8'h44, 8'h08, 8'h20
	};

	typedef struct packed {
		logic ctrl_bus_en_n;
		logic ctrl_video_suppress;
		logic erase_req_n;
		logic ctrl_source_select;
		logic local_addr_top;
		logic high_byte_active;
		logic [15:0] ctrl_addr_data;
	} vtb_pins_t;

	typedef struct packed {
		vtb_pins_t pin_s1;
		vtb_pins_t pin_s2;
		vtb_pins_t pin_s3;
		vtb_pins_t pin_f;
		logic [2:0] div;
		logic [3:0] cnt;
		logic clr;
		logic msb;
		logic [7:0] tim;
		logic [7:0] tim_prev;
		logic rmw;
		logic erase;
		logic rmw_prev;
		logic sblank;
		logic blank;
		logic [2:0] dpipe;
		logic ps;
		logic bs;
		logic [13:0] scroll;
		logic [15:0] latched;
		logic [7:0] mem_addr;
		logic [7:0] mode0;
		logic [7:0] mode1;
		logic [5:0] wmode;
		logic ack;
		logic [31:0] rdata;
	} vtb_state_t;

endpackage

// ---- vtb_ctrl_model.sv ----
`timescale 1ns/1ps
// stands in for the display controller pins; drives on rising edges only
module vtb_ctrl_model
	import vtb_pkg::*;
(
	input wire logic core_clk,
	input wire logic slow,
	input wire vtb_pins_t want,
	output vtb_pins_t pins
);
	logic tick;
	vtb_pins_t p;
	initial begin
		pins = '1;
		tick = 1'b0;
	end
	// slow mode answers every other clock, like a busy controller
	always @(posedge core_clk) begin
		tick <= ~tick;
		if (!slow || tick) begin
			p = want;
			// a released address bus does not keep its last value
			if (want.ctrl_bus_en_n)
				p.ctrl_addr_data = ~pins.ctrl_addr_data;
			pins <= p;
		end
	end
endmodule

// ---- tb_vtb_top.sv ----
`timescale 1ns/1ps
module tb_vtb_top
	import vtb_pkg::*;
;
	logic core_clk, srst, avs_read, avs_write, slow, armed, hp, rp, d2, d8;
	logic hq;
	logic [4:0] avs_address, timing_rom_addr, ap;
	logic [31:0] avs_writedata, avs_readdata, rd, d, h;
	logic [3:0] avs_byteenable;
	logic avs_waitrequest, clk_div2_n, clk_div8_n, buffered_ctrl_bus_en_n;
	logic bus_en, timing_halt_n, data_bus_en_n, rmw_cycle_n, rmw_cycle;
	logic screen_blank_n, video_blank_n, video_blank, dac_blank_n;
	logic plane_select, byte_select_n, display_addr_bit3, vector_mode_n;
	logic display_addr_select_n, local_addr_select_n;
	logic write_mask_zero, bg_erase, ps_seen, bs_seen;
	logic [7:0] timing_out, mem_addr;
	logic [5:0] write_mode_sel;
	logic [2:0] vbh;
	logic [4:0] ofs [5];
	vtb_pins_t want, pins;
	int n_errors, num_checks, seed, m, n8, nh;

	vtb_top vtb_top_inst (.core_clk, .srst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .pins, .clk_div2_n, .clk_div8_n,
		.buffered_ctrl_bus_en_n, .bus_en, .timing_halt_n, .data_bus_en_n,
		.timing_rom_addr, .timing_out, .rmw_cycle_n, .rmw_cycle,
		.screen_blank_n, .video_blank_n, .video_blank, .dac_blank_n,
		.plane_select, .byte_select_n, .display_addr_bit3, .vector_mode_n,
		.display_addr_select_n, .local_addr_select_n, .mem_addr,
		.write_mode_sel, .write_mask_zero, .bg_erase);
	vtb_ctrl_model vtb_ctrl_model_inst (.core_clk, .slow, .want, .pins);

	// 10 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic report_and_stop();
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] e, input logic [31:0] g,
		input string what);
		num_checks++;
		if (e !== g) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	// one avalon access; the request stays put until waitrequest is low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] wd, input logic [3:0] be);
		int k;
		armed = 1'b0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_byteenable <= be;
		avs_read <= ~wr;
		avs_write <= wr;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 20);
		if (k >= 20) begin
			chk(32'h0, 32'h1, "bus wait");
			report_and_stop();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask

	// one clock; outputs looked at mid-cycle, where they have settled
	task automatic step();
		@(negedge core_clk);
		if (armed) begin
			chk(!(timing_out[VTB_T_HALT] && bus_en), timing_halt_n, "halt");
			chk(!(timing_out[VTB_T_DBEN] && bus_en), data_bus_en_n, "dben");
			chk(!bus_en, buffered_ctrl_bus_en_n, "ben pair");
			chk(!rmw_cycle, rmw_cycle_n, "rmw pair");
			chk(!video_blank, video_blank_n, "blank pair");
			chk(vbh[2], dac_blank_n, "dac blank");
			chk(!d2, clk_div2_n, "div2");
			// the clear flop lags halt, so the halt of two clocks back counts
			chk(hq ? 4'(ap[3:0] + 4'h1) : 4'h0, timing_rom_addr[3:0], "cnt");
			chk(VTB_TIMING_ROM[ap], timing_out, "table");
			if (!rp && !timing_out[VTB_T_RAS])
				chk(1'b0, plane_select, "plane idle");
			if (clk_div8_n !== d8)
				n8++;
		end
		if (timing_halt_n === 1'b0)
			nh++;
		ps_seen |= plane_select;
		bs_seen |= plane_select & !byte_select_n;
		hq = armed ? hp : timing_halt_n;
		vbh = armed ? {vbh[1:0], video_blank_n} : {3{video_blank_n}};
		{ap, hp, rp, d2, d8} = {timing_rom_addr, timing_halt_n,
			timing_out[VTB_T_RAS], clk_div2_n, clk_div8_n};
		armed = 1'b1;
		@(posedge core_clk);
	endtask

	initial begin
		seed = 32'h2dd26f94;
		{srst, avs_read, avs_write, slow, armed, ps_seen, bs_seen} = 7'h40;
		{avs_address, avs_writedata, avs_byteenable} = '0;
		{n_errors, num_checks, n8, nh} = '0;
		want = '1;
		want.ctrl_video_suppress = 1'b0;
		want.ctrl_addr_data = 16'(seed);
		ofs = '{VTB_OFS_MODE0, VTB_OFS_MODE1, VTB_OFS_SCROLL_LO,
			VTB_OFS_SCROLL_HI, 5'h18};
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		// reset values, a masked write and an unmapped place
		bus(1'b1, VTB_OFS_MODE1, 32'hff, 4'he);
		bus(1'b1, 5'h18, 32'hff, 4'hf);
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], 32'h0, 4'hf);
			chk(32'h0, rd, "reset value");
		end
		// free run: full table period, divider and address top bit
		repeat (33) step();
		chk(8, n8, "div8 toggles");
		chk(1'b1, timing_rom_addr[4], "msb idle");
		bus(1'b1, VTB_OFS_MODE1, 32'h1, 4'hf);
		repeat (3) step();
		chk(1'b0, timing_rom_addr[4], "msb scroll");
		bus(1'b1, VTB_OFS_MODE1, 32'h0, 4'hf);
		// every write mode code, reserved codes included
		want.local_addr_top <= 1'($random(seed));
		want.high_byte_active <= 1'($random(seed));
		repeat (6) step();
		for (m = 0; m < 8; m++) begin
			d = $random(seed);
			d[2:0] = 3'(m);
			bus(1'b1, VTB_OFS_MODE0, d, 4'hf);
			repeat (2) step();
			chk(m > 5 ? 6'h01 : 6'h01 << m, write_mode_sel, "mode");
			chk(m == 3, write_mask_zero, "mask zero");
			chk(m == 4 || m == 5, bg_erase, "bg erase");
			chk(m != 2, vector_mode_n, "vector");
			chk(m == 2 ? !want.high_byte_active : !want.local_addr_top,
				display_addr_bit3, "addr bit3");
			bus(1'b0, VTB_OFS_MODE0, 32'h0, 4'hf);
			chk(d[7:0], rd, "mode0 back");
		end
		bus(1'b1, VTB_OFS_MODE0, 32'h0, 4'hf);
		// scroll counter byte loads, high byte first
		d = $random(seed);
		h = $random(seed);
		bus(1'b1, VTB_OFS_SCROLL_HI, h, 4'hf);
		bus(1'b1, VTB_OFS_SCROLL_LO, d, 4'hf);
		bus(1'b0, VTB_OFS_SCROLL_LO, 32'h0, 4'hf);
		chk(d[7:0], rd, "scroll lo");
		bus(1'b0, VTB_OFS_SCROLL_HI, 32'h0, 4'hf);
		chk(h[5:0], rd, "scroll hi");
		// slow controller takes the bus: halt, then release
		slow <= 1'b1;
		want.ctrl_bus_en_n <= 1'b0;
		repeat (60) step();
		chk(1'b1, bus_en, "bus en");
		chk(1'b1, nh > 0, "halt seen");
		chk(1'b1, rmw_cycle, "rmw set");
		want.ctrl_bus_en_n <= 1'b1;
		repeat (40) step();
		chk(1'b0, rmw_cycle, "rmw clear");
		want.erase_req_n <= 1'b0;
		repeat (40) step();
		chk(1'b1, rmw_cycle, "erase rmw");
		want.erase_req_n <= 1'b1;
		// blanking from the controller
		want.ctrl_video_suppress <= 1'b1;
		repeat (40) step();
		chk(1'b0, video_blank_n, "blank");
		chk(1'b0, screen_blank_n, "screen blank");
		chk(1'b0, dac_blank_n, "dac blank end");
		chk(1'b1, ps_seen, "plane select");
		chk(1'b1, bs_seen, "byte select");
		// scrolled blanking opens the source decoder; source pin is high
		bus(1'b1, VTB_OFS_MODE1, 32'h1, 4'hf);
		repeat (20) step();
		chk(1'b0, local_addr_select_n, "lad sel");
		chk(1'b1, display_addr_select_n, "dad sel");
		report_and_stop();
	end
endmodule
